/* File: rtl/mcuix_adder.sv */
// Eight-bit adder with carry, nibble carry and signed overflow outputs
module mcuix_adder
	import mcuix_pkg::*;
(
	// Operands
	input  wire logic [7:0] a_i,
	input  wire logic [7:0] b_i,
	input  wire logic       cin_i,
	// Result and flags
	output logic      [7:0] sum_o,
	output logic            carry_o,
	output logic            nibble_carry_o,
	output logic            overflow_o
);
	logic [4:0] low_sum;
	logic [4:0] high_sum;
	logic [3:0] low7;

	assign low_sum        = {1'b0, a_i[3:0]} + {1'b0, b_i[3:0]} + {4'h0, cin_i};
	assign high_sum       = {1'b0, a_i[7:4]} + {1'b0, b_i[7:4]} + {4'h0, low_sum[4]};
	assign low7           = {1'b0, a_i[6:4]} + {1'b0, b_i[6:4]} + {3'h0, low_sum[4]};
	assign sum_o          = {high_sum[3:0], low_sum[3:0]};
	assign carry_o        = high_sum[4];
	assign nibble_carry_o = low_sum[4];
	// Overflow is carry into bit 7 differing from carry out
	assign overflow_o     = low7[3] ^ high_sum[4];
endmodule

/* File: rtl/mcuix_exec.sv */
// Execute stage for a subset of an 8-bit microcontroller instruction set
// Notes on behaviour
// - Current-page table read: high to table byte, two cycles
// - Last-page table read, same, from last page
// - Skip takes two cycles, no skip one
// - Writing program counter low byte takes two cycles
// - Pre-clear pair clears both flags once consecutive
// - Repeated same pre-clear has no effect
// - Single watchdog clear clears counter and flags
// - All additions update overflow, zero, nibble, carry
// - Add with carry result to working register
// - Add with carry result to memory
// - Plain add to working or memory
// - Immediate add into working register
// - AND to working or memory, zero only
// - Call pushes pc plus one, two cycles
// - Byte clear writes zero, no flags
// - Bit clear zeroes selected bit only
// - Complement memory in place, zero flag only
// - Complement into working register, zero only
// - Nibble swap to memory or working, no flags
// - Decimal adjust working register into memory
// - Add 06 and/or 60, only carry changes
// - Power down stops, clears watchdog, sets powerdown
module mcuix_exec
	import mcuix_pkg::*;
#(
	parameter int PC_W   = MCUIX_PC_W,
	parameter int ADDR_W = MCUIX_ADDR_W
)
(
	// Clock and reset
	input  wire logic              clock_i,
	input  wire logic              rst_n_i,
	// Instruction issue from fetch logic
	input  wire logic              issue_valid_i,
	input  wire mcuix_op_t         issue_op_i,
	input  wire logic [7:0]        immediate_i,
	input  wire logic [ADDR_W-1:0] mem_addr_i,
	input  wire logic [2:0]        bit_select_i,
	input  wire logic [PC_W-1:0]   target_addr_i,
	input  wire logic [PC_W-1:0]   program_counter_i,
	input  wire logic              wakeup_i,
	output logic                   issue_ready_o,
	// Data memory: read data is combinational for mem_addr_i
	input  wire logic [7:0]        mem_rdata_i,
	output logic                   mem_we_o,
	output logic [ADDR_W-1:0]      mem_waddr_o,
	output logic [7:0]             mem_wdata_o,
	// Program memory table port, word returned one cycle after request
	output logic                   table_req_o,
	output logic                   table_last_page_o,
	input  wire logic [15:0]       table_word_i,
	// Return stack and program counter load
	output logic                   stack_push_o,
	output logic [PC_W-1:0]        stack_data_o,
	output logic                   pc_load_o,
	output logic [PC_W-1:0]        pc_load_addr_o,
	output logic                   skip_next_o,
	// Watchdog and power control
	output logic                   watchdog_counter_clear_o,
	output logic                   powered_down_o,
	// Architectural state
	output logic [7:0]             working_register_o,
	output logic [7:0]             table_high_byte_o,
	output logic                   carry_flag_o,
	output logic                   nibble_carry_flag_o,
	output logic                   signed_range_exceeded_flag_o,
	output logic                   zero_flag_o,
	output logic                   watchdog_expired_flag_o,
	output logic                   powerdown_flag_o,
	input  wire logic              watchdog_timeout_i
);
	typedef enum logic [1:0] {MCUIX_RUN, MCUIX_SECOND, MCUIX_SLEEP} mcuix_state_t;

	mcuix_state_t      state_reg, state_next;
	mcuix_op_t         pend_op_reg;
	logic [ADDR_W-1:0] pend_addr_reg;
	logic [7:0]        acc_reg, tbl_reg;
	logic              c_reg, ac_reg, ov_reg, z_reg, to_reg, pdf_reg;
	// Pre-clear tracking: which half ran last (0 none, 1 first, 2 second)
	logic [1:0]        pre_last_reg;
	logic [7:0]        wdata_reg;
	logic              we_reg;

	wire run_go = (state_reg == MCUIX_RUN) && issue_valid_i;
	wire op_adc  = issue_op_i == MCUIX_OP_ADC;
	wire op_add_with_carry_to_memory = issue_op_i == MCUIX_OP_ADD_WITH_CARRY_TO_MEMORY;
	wire op_add  = issue_op_i == MCUIX_OP_ADD;
	wire op_sum_to_memory = issue_op_i == MCUIX_OP_SUM_TO_MEMORY;
	wire op_addi = issue_op_i == MCUIX_OP_ADDI;
	wire is_add  = op_adc | op_add_with_carry_to_memory | op_add | op_sum_to_memory | op_addi;
	wire use_cin = op_adc | op_add_with_carry_to_memory;
	wire is_and  = (issue_op_i == MCUIX_OP_AND) | (issue_op_i == MCUIX_OP_BITWISE_AND_TO_MEMORY)
		| (issue_op_i == MCUIX_OP_ANDI);
	wire op_tab  = (issue_op_i == MCUIX_OP_TABLE_READ_CURRENT_PAGE_CUR) | (issue_op_i == MCUIX_OP_TABLE_READ_CURRENT_PAGE_LAST);
	wire op_two  = op_tab | (issue_op_i == MCUIX_OP_CALL) | (issue_op_i == MCUIX_OP_WRPCL)
		| ((issue_op_i == MCUIX_OP_SKIPZ) && (mem_rdata_i == MCUIX_ZERO_BYTE));

	// Operand selection and adder
	wire [7:0] add_b = op_addi ? immediate_i : mem_rdata_i;
	logic [7:0] add_sum;
	logic       add_c, add_ac, add_ov;

	mcuix_adder u_adder (
		.a_i            (acc_reg),
		.b_i            (add_b),
		.cin_i          (use_cin & c_reg),
		.sum_o          (add_sum),
		.carry_o        (add_c),
		.nibble_carry_o (add_ac),
		.overflow_o     (add_ov)
	);

	wire [7:0] and_res  = acc_reg & ((issue_op_i == MCUIX_OP_ANDI) ? immediate_i : mem_rdata_i);
	wire [7:0] inv_res  = ~mem_rdata_i;
	wire [7:0] swap_res = {mem_rdata_i[3:0], mem_rdata_i[7:4]};
	wire [7:0] bit_mask = 8'h01 << bit_select_i;
	wire [7:0] bclr_res = mem_rdata_i & ~bit_mask;

	// Decimal adjust
	wire       daa_lo   = (acc_reg[3:0] > MCUIX_BCD_MAX) | ac_reg;
	wire       daa_hi   = (acc_reg[7:4] > MCUIX_BCD_MAX) | c_reg;
	wire [7:0] daa_add  = (daa_lo ? MCUIX_ADJ_LOW : MCUIX_ZERO_BYTE)
		| (daa_hi ? MCUIX_ADJ_HIGH : MCUIX_ZERO_BYTE);
	wire [8:0] daa_sum  = {1'b0, acc_reg} + {1'b0, daa_add};

	// Watchdog clear decoding
	wire op_pre1   = issue_op_i == MCUIX_OP_WDPRE1;
	wire op_pre2   = issue_op_i == MCUIX_OP_WDPRE2;
	wire pre_pair  = (op_pre1 && pre_last_reg == 2'h2) || (op_pre2 && pre_last_reg == 2'h1);
	wire wd_single = run_go && issue_op_i == MCUIX_OP_WDCLR;
	wire wd_pair   = run_go && pre_pair;
	wire halt_go   = run_go && issue_op_i == MCUIX_OP_HALT;

	// Result writeback decode
	logic [7:0] res;
	logic       to_mem, to_acc, set_z, set_arith;
	always_comb begin
		res       = MCUIX_ZERO_BYTE;
		to_mem    = 1'b0;
		to_acc    = 1'b0;
		set_z     = 1'b0;
		set_arith = 1'b0;
		case (issue_op_i)
			MCUIX_OP_ADC, MCUIX_OP_ADD, MCUIX_OP_ADDI: begin
				res       = add_sum;
				to_acc    = 1'b1;
				set_arith = 1'b1;
			end
			MCUIX_OP_ADD_WITH_CARRY_TO_MEMORY, MCUIX_OP_SUM_TO_MEMORY: begin
				res       = add_sum;
				to_mem    = 1'b1;
				set_arith = 1'b1;
			end
			MCUIX_OP_AND, MCUIX_OP_ANDI: begin
				res    = and_res;
				to_acc = 1'b1;
				set_z  = 1'b1;
			end
			MCUIX_OP_BITWISE_AND_TO_MEMORY: begin
				res    = and_res;
				to_mem = 1'b1;
				set_z  = 1'b1;
			end
			MCUIX_OP_CLR: begin
				res    = MCUIX_ZERO_BYTE;
				to_mem = 1'b1;
			end
			MCUIX_OP_SET: begin
				res    = ~MCUIX_ZERO_BYTE;
				to_mem = 1'b1;
			end
			MCUIX_OP_CLRBIT: begin
				res    = bclr_res;
				to_mem = 1'b1;
			end
			MCUIX_OP_CPL: begin
				res    = inv_res;
				to_mem = 1'b1;
				set_z  = 1'b1;
			end
			MCUIX_OP_INVERT_TO_WORKING: begin
				res    = inv_res;
				to_acc = 1'b1;
				set_z  = 1'b1;
			end
			MCUIX_OP_SWAP: begin
				res    = swap_res;
				to_mem = 1'b1;
			end
			MCUIX_OP_NIBBLE_EXCHANGE_TO_WORKING: begin
				res    = swap_res;
				to_acc = 1'b1;
			end
			MCUIX_OP_DAA: begin
				res    = daa_sum[7:0];
				to_mem = 1'b1;
			end
			default: begin
				res = MCUIX_ZERO_BYTE;
			end
		endcase
	end

	// Sequencing: two-cycle instructions hold issue for one extra cycle
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			MCUIX_RUN: begin
				if (halt_go) begin
					state_next = MCUIX_SLEEP;
				end else if (run_go && op_two) begin
					state_next = MCUIX_SECOND;
				end
			end
			MCUIX_SECOND: state_next = MCUIX_RUN;
			MCUIX_SLEEP: begin
				if (wakeup_i) begin
					state_next = MCUIX_RUN;
				end
			end
			default: state_next = MCUIX_RUN;
		endcase
	end

	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_reg     <= MCUIX_RUN;
			pend_op_reg   <= MCUIX_OP_NOP;
			pend_addr_reg <= '0;
			pre_last_reg  <= 2'h0;
			we_reg        <= 1'b0;
			wdata_reg     <= MCUIX_ZERO_BYTE;
		end else begin
			state_reg <= state_next;
			if (run_go) begin
				pend_op_reg   <= issue_op_i;
				pend_addr_reg <= mem_addr_i;
			end
			// Any other instruction breaks the pre-clear alternation
			if (run_go) begin
				if (pre_pair) begin
					pre_last_reg <= 2'h0;
				end else if (op_pre1) begin
					pre_last_reg <= 2'h1;
				end else if (op_pre2) begin
					pre_last_reg <= 2'h2;
				end else begin
					pre_last_reg <= 2'h0;
				end
			end
			// Table read writes memory low byte in its second cycle
			we_reg    <= (run_go && to_mem) || (state_reg == MCUIX_SECOND && pend_op_reg inside
				{MCUIX_OP_TABLE_READ_CURRENT_PAGE_CUR, MCUIX_OP_TABLE_READ_CURRENT_PAGE_LAST});
			wdata_reg <= (state_reg == MCUIX_SECOND) ? table_word_i[7:0] : res;
		end
	end

	logic [ADDR_W-1:0] waddr_reg;
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			waddr_reg <= '0;
		end else begin
			waddr_reg <= (state_reg == MCUIX_SECOND) ? pend_addr_reg : mem_addr_i;
		end
	end

	// Architectural registers
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			acc_reg <= MCUIX_ACC_RESET;
			tbl_reg <= MCUIX_ZERO_BYTE;
			c_reg   <= MCUIX_FLAG_RESET;
			ac_reg  <= MCUIX_FLAG_RESET;
			ov_reg  <= MCUIX_FLAG_RESET;
			z_reg   <= MCUIX_FLAG_RESET;
		end else begin
			if (run_go && to_acc) begin
				acc_reg <= res;
			end
			if (run_go && (set_arith || set_z)) begin
				z_reg <= (res == MCUIX_ZERO_BYTE);
			end
			if (run_go && set_arith) begin
				c_reg  <= add_c;
				ac_reg <= add_ac;
				ov_reg <= add_ov;
			end
			if (run_go && issue_op_i == MCUIX_OP_DAA) begin
				// Carry is only ever set, keeping multi-byte decimal chains
				c_reg <= c_reg | daa_sum[8] | daa_hi;
			end
			if (state_reg == MCUIX_SECOND && pend_op_reg inside
				{MCUIX_OP_TABLE_READ_CURRENT_PAGE_CUR, MCUIX_OP_TABLE_READ_CURRENT_PAGE_LAST}) begin
				tbl_reg <= table_word_i[15:8];
			end
		end
	end

	// Watchdog and power flags: timeout sets win over clears
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			to_reg  <= MCUIX_FLAG_RESET;
			pdf_reg <= MCUIX_FLAG_RESET;
		end else begin
			if (watchdog_timeout_i) begin
				to_reg <= 1'b1;
			end else if (wd_single || wd_pair || halt_go) begin
				to_reg <= 1'b0;
			end
			if (halt_go) begin
				pdf_reg <= 1'b1;
			end else if (wd_single || wd_pair) begin
				pdf_reg <= 1'b0;
			end
		end
	end

	assign issue_ready_o                = (state_reg == MCUIX_RUN);
	assign mem_we_o                     = we_reg;
	assign mem_waddr_o                  = waddr_reg;
	assign mem_wdata_o                  = wdata_reg;
	assign table_req_o                  = run_go && op_tab;
	assign table_last_page_o            = run_go && issue_op_i == MCUIX_OP_TABLE_READ_CURRENT_PAGE_LAST;
	assign stack_push_o                 = run_go && issue_op_i == MCUIX_OP_CALL;
	assign stack_data_o                 = program_counter_i + PC_W'(1);
	assign pc_load_o                    = run_go && issue_op_i == MCUIX_OP_CALL;
	assign pc_load_addr_o               = target_addr_i;
	assign skip_next_o                  = run_go && issue_op_i == MCUIX_OP_SKIPZ
		&& mem_rdata_i == MCUIX_ZERO_BYTE;
	assign watchdog_counter_clear_o     = wd_single || wd_pair || halt_go;
	assign powered_down_o               = (state_reg == MCUIX_SLEEP);
	assign working_register_o           = acc_reg;
	assign table_high_byte_o            = tbl_reg;
	assign carry_flag_o                 = c_reg;
	assign nibble_carry_flag_o          = ac_reg;
	assign signed_range_exceeded_flag_o = ov_reg;
	assign zero_flag_o                  = z_reg;
	assign watchdog_expired_flag_o      = to_reg;
	assign powerdown_flag_o             = pdf_reg;
endmodule

/* File: rtl/mcuix_pkg.sv */
// Package for the instruction execute subset: opcodes, cycle counts, constants
package mcuix_pkg;
	typedef enum logic [4:0] {
		MCUIX_OP_NOP,
		MCUIX_OP_ADC,
		MCUIX_OP_ADD_WITH_CARRY_TO_MEMORY,
		MCUIX_OP_ADD,
		MCUIX_OP_SUM_TO_MEMORY,
		MCUIX_OP_ADDI,
		MCUIX_OP_AND,
		MCUIX_OP_BITWISE_AND_TO_MEMORY,
		MCUIX_OP_ANDI,
		MCUIX_OP_CALL,
		MCUIX_OP_CLR,
		MCUIX_OP_SET,
		MCUIX_OP_CLRBIT,
		MCUIX_OP_CPL,
		MCUIX_OP_INVERT_TO_WORKING,
		MCUIX_OP_SWAP,
		MCUIX_OP_NIBBLE_EXCHANGE_TO_WORKING,
		MCUIX_OP_DAA,
		MCUIX_OP_TABLE_READ_CURRENT_PAGE_CUR,
		MCUIX_OP_TABLE_READ_CURRENT_PAGE_LAST,
		MCUIX_OP_WDCLR,
		MCUIX_OP_WDPRE1,
		MCUIX_OP_WDPRE2,
		MCUIX_OP_HALT,
		MCUIX_OP_SKIPZ,
		MCUIX_OP_WRPCL
	} mcuix_op_t;

	localparam logic [1:0] MCUIX_CYC_ONE    = 2'h1;
	localparam logic [1:0] MCUIX_CYC_TWO    = 2'h2;
	localparam logic [7:0] MCUIX_ZERO_BYTE  = 8'h00;
	localparam logic [7:0] MCUIX_ADJ_LOW    = 8'h06;
	localparam logic [7:0] MCUIX_ADJ_HIGH   = 8'h60;
	localparam logic [3:0] MCUIX_BCD_MAX    = 4'h9;
	localparam logic [7:0] MCUIX_ACC_RESET  = 8'h00;
	localparam logic       MCUIX_FLAG_RESET = 1'b0;
	localparam int         MCUIX_PC_W       = 12;
	localparam int         MCUIX_ADDR_W     = 9;
endpackage

/* File: tb/mcuix_exec_checker.sv */
// Port-level assertions for the instruction execute subset
module mcuix_exec_checker
	import mcuix_pkg::*;
#(
	parameter int PC_W   = MCUIX_PC_W,
	parameter int ADDR_W = MCUIX_ADDR_W
)
(
	// Clock, reset and issue side
	input wire logic              clock_i,
	input wire logic              rst_n_i,
	input wire logic              issue_valid_i,
	input wire mcuix_op_t         issue_op_i,
	input wire logic [7:0]        immediate_i,
	input wire logic [PC_W-1:0]   program_counter_i,
	input wire logic [PC_W-1:0]   target_addr_i,
	input wire logic [7:0]        mem_rdata_i,
	input wire logic              issue_ready_o,
	// Design outputs watched
	input wire logic              mem_we_o,
	input wire logic [7:0]        mem_wdata_o,
	input wire logic              table_req_o,
	input wire logic              stack_push_o,
	input wire logic [PC_W-1:0]   stack_data_o,
	input wire logic              pc_load_o,
	input wire logic [PC_W-1:0]   pc_load_addr_o,
	input wire logic              skip_next_o,
	input wire logic              watchdog_counter_clear_o,
	input wire logic              powered_down_o,
	input wire logic [7:0]        working_register_o,
	input wire logic              carry_flag_o,
	input wire logic              zero_flag_o,
	input wire logic              watchdog_expired_flag_o,
	input wire logic              powerdown_flag_o
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clock_i); endclocking
	default disable iff (!rst_n_i);

	logic take;
	assign take = issue_valid_i && issue_ready_o;

	sequence s_pre1;
		take && issue_op_i == MCUIX_OP_WDPRE1;
	endsequence
	sequence s_pre2;
		take && issue_op_i == MCUIX_OP_WDPRE2;
	endsequence

	a_table_two_cycle: assert property (table_req_o |=> !issue_ready_o ##1 issue_ready_o)
		else $error("table read not two cycles");
	a_skip_two_cycle: assert property (take && issue_op_i == MCUIX_OP_SKIPZ && mem_rdata_i == 8'h00
		|-> skip_next_o ##1 !issue_ready_o) else $error("taken skip not two cycles");
	a_pcl_two_cycle: assert property (take && issue_op_i == MCUIX_OP_WRPCL
		|=> !issue_ready_o ##1 issue_ready_o) else $error("pcl write not two cycles");
	a_pair_clears: assert property (s_pre1 ##1 s_pre2
		|-> watchdog_counter_clear_o ##1 !powerdown_flag_o) else $error("pre-clear pair ignored");
	a_repeat_no_effect: assert property (s_pre1 ##1 s_pre1
		|-> !watchdog_counter_clear_o ##1 $stable(powerdown_flag_o)) else $error("repeat pre-clear acted");
	a_wdclr_clears: assert property (take && issue_op_i == MCUIX_OP_WDCLR
		|-> watchdog_counter_clear_o ##1 !powerdown_flag_o) else $error("watchdog clear failed");
	a_addi_sum: assert property (take && issue_op_i == MCUIX_OP_ADDI
		|=> working_register_o == $past(working_register_o) + $past(immediate_i))
		else $error("immediate add wrong");
	a_call_push: assert property (stack_push_o
		|-> pc_load_o && stack_data_o == program_counter_i + 1'b1 && pc_load_addr_o == target_addr_i)
		else $error("call push wrong");
	a_clear_zero: assert property (take && issue_op_i == MCUIX_OP_CLR
		|=> mem_we_o && mem_wdata_o == 8'h00 && $stable(carry_flag_o) && $stable(zero_flag_o))
		else $error("byte clear wrong");
	a_halt_sleeps: assert property (take && issue_op_i == MCUIX_OP_HALT
		|-> watchdog_counter_clear_o ##1 powerdown_flag_o && powered_down_o && !issue_ready_o)
		else $error("power down wrong");
endmodule

bind mcuix_exec mcuix_exec_checker #(.PC_W(PC_W), .ADDR_W(ADDR_W)) u_checker (.*);

/* File: tb/mcuix_exec_test.sv */
// Self-checking testbench for the instruction execute subset
module mcuix_exec_test
	import mcuix_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic clock_i, rst_n_i, issue_valid_i, wakeup_i, watchdog_timeout_i, issue_ready_o;
	logic mem_we_o, table_req_o, table_last_page_o, stack_push_o, pc_load_o, skip_next_o;
	logic watchdog_counter_clear_o, powered_down_o, carry_flag_o, nibble_carry_flag_o;
	logic signed_range_exceeded_flag_o, zero_flag_o, watchdog_expired_flag_o, powerdown_flag_o;
	mcuix_op_t   issue_op_i;
	logic [7:0]  immediate_i, mem_rdata_i, mem_wdata_o, working_register_o, table_high_byte_o, wd;
	logic [8:0]  mem_addr_i, mem_waddr_o;
	logic [2:0]  bit_select_i;
	logic [11:0] target_addr_i, program_counter_i, stack_data_o, pc_load_addr_o;
	logic [15:0] table_word_i;
	logic [3:0]  flags;
	int          num_errors, compares;

	assign flags = {carry_flag_o, nibble_carry_flag_o, signed_range_exceeded_flag_o, zero_flag_o};
	always #2.5 clock_i = ~clock_i;

	mcuix_exec dut (.*);
	mcuix_mem_model u_mem (.clock_i(clock_i), .mem_addr_i(mem_addr_i), .mem_rdata_o(mem_rdata_i),
		.mem_we_i(mem_we_o), .mem_waddr_i(mem_waddr_o), .mem_wdata_i(mem_wdata_o),
		.table_req_i(table_req_o), .table_last_page_i(table_last_page_o),
		.table_word_o(table_word_i), .wd_clear_i(watchdog_counter_clear_o), .wd_count_o(wd));

	task automatic test_done();
		$display("Comparisons %0d, mismatches %0d", compares, num_errors);
		if (num_errors == 0 && compares > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp) begin
			num_errors++;
			$display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// Issue one instruction; valid stays up so calls run back to back
	task automatic exec(input mcuix_op_t op, input logic [8:0] a, input logic [7:0] imm);
		int n;
		@(negedge clock_i);
		issue_valid_i = 1'b1;
		issue_op_i = op;
		mem_addr_i = a;
		immediate_i = imm;
		n = 0;
		while (issue_ready_o !== 1'b1 && n < 20) begin
			@(negedge clock_i);
			n++;
		end
		if (n == 20) begin
			num_errors++;
			test_done();
		end
		@(posedge clock_i);
		#1;
	endtask

	task automatic idle(input int n);
		@(negedge clock_i);
		issue_valid_i = 1'b0;
		repeat (n) @(posedge clock_i);
		#1;
	endtask

	// Wake from sleep with a watchdog expiry arriving meanwhile
	task automatic wake();
		@(negedge clock_i);
		// Drop the last offer so it is not issued again after wake-up
		issue_valid_i = 1'b0;
		wakeup_i = 1'b1;
		watchdog_timeout_i = 1'b1;
		@(negedge clock_i);
		wakeup_i = 1'b0;
		watchdog_timeout_i = 1'b0;
	endtask

	initial begin
		{clock_i, rst_n_i, issue_valid_i, wakeup_i, watchdog_timeout_i} = '0;
		issue_op_i = MCUIX_OP_NOP;
		{immediate_i, mem_addr_i} = '0;
		bit_select_i = 3'h3;
		program_counter_i = 12'h123;
		target_addr_i = 12'h456;
		{u_mem.mem[5], u_mem.mem[6], u_mem.mem[7], u_mem.mem[8]} = 32'h1022050a;
		{u_mem.mem[9], u_mem.mem[10], u_mem.mem[11], u_mem.mem[12]} = 32'haaff0fff;
		{u_mem.mem[13], u_mem.mem[14]} = 16'h1234;
		repeat (10) @(posedge clock_i);
		@(negedge clock_i);
		rst_n_i = 1'b1;
		chk({working_register_o, flags, 3'h0, issue_ready_o}, 16'h0001);
		exec(MCUIX_OP_ADDI, 0, 8'h7f);
		exec(MCUIX_OP_ADDI, 0, 8'h01);
		chk({working_register_o, flags}, 12'h806);
		exec(MCUIX_OP_ADDI, 0, 8'h80);
		chk({working_register_o, flags}, 12'h00b);
		exec(MCUIX_OP_ADC, 5, 0);
		chk({working_register_o, flags}, 12'h110);
		exec(MCUIX_OP_ADDI, 0, 8'hff);
		chk({working_register_o, flags}, 12'h10c);
		exec(MCUIX_OP_ADD_WITH_CARRY_TO_MEMORY, 6, 0);
		exec(MCUIX_OP_SUM_TO_MEMORY, 7, 0);
		idle(2);
		exec(MCUIX_OP_ADD, 7, 0);
		chk(working_register_o, 8'h25);
		exec(MCUIX_OP_AND, 8, 0);
		chk({working_register_o, flags}, 12'h001);
		exec(MCUIX_OP_BITWISE_AND_TO_MEMORY, 7, 0);
		exec(MCUIX_OP_ADDI, 0, 8'h3c);
		exec(MCUIX_OP_ANDI, 0, 8'h0f);
		chk({working_register_o, flags}, 12'h0c0);
		exec(MCUIX_OP_CLR, 9, 0);
		exec(MCUIX_OP_CLRBIT, 10, 0);
		exec(MCUIX_OP_INVERT_TO_WORKING, 12, 0);
		chk({working_register_o, flags}, 12'h001);
		exec(MCUIX_OP_CPL, 11, 0);
		chk(zero_flag_o, 1'b0);
		exec(MCUIX_OP_SWAP, 13, 0);
		exec(MCUIX_OP_NIBBLE_EXCHANGE_TO_WORKING, 14, 0);
		chk({working_register_o, flags}, 12'h430);
		exec(MCUIX_OP_ADDI, 0, 8'h38);
		exec(MCUIX_OP_DAA, 15, 0);
		chk(carry_flag_o, 1'b0);
		idle(3);
		chk({u_mem.mem[6], u_mem.mem[7]}, 16'h3300);
		chk({u_mem.mem[9], u_mem.mem[10]}, 16'h00f7);
		chk({u_mem.mem[11], u_mem.mem[12]}, 16'hf0ff);
		chk({u_mem.mem[13], u_mem.mem[15]}, 16'h2181);
		exec(MCUIX_OP_TABLE_READ_CURRENT_PAGE_CUR, 16, 0);
		chk(issue_ready_o, 1'b0);
		exec(MCUIX_OP_TABLE_READ_CURRENT_PAGE_LAST, 17, 0);
		chk({table_high_byte_o, issue_ready_o}, 9'h0b4);
		idle(3);
		chk({u_mem.mem[16], u_mem.mem[17]}, 16'hc33c);
		chk(table_high_byte_o, 8'ha5);
		exec(MCUIX_OP_CALL, 0, 0);
		chk(issue_ready_o, 1'b0);
		exec(MCUIX_OP_WRPCL, 0, 0);
		chk(issue_ready_o, 1'b0);
		exec(MCUIX_OP_SKIPZ, 9, 0);
		chk(issue_ready_o, 1'b0);
		exec(MCUIX_OP_SKIPZ, 13, 0);
		chk(issue_ready_o, 1'b1);
		wake();
		exec(MCUIX_OP_HALT, 0, 0);
		chk({watchdog_expired_flag_o, powerdown_flag_o, powered_down_o}, 3'b011);
		wake();
		exec(MCUIX_OP_WDPRE1, 0, 0);
		exec(MCUIX_OP_WDPRE1, 0, 0);
		chk({watchdog_expired_flag_o, powerdown_flag_o, 7'h0, wd == 8'h00}, 10'h300);
		exec(MCUIX_OP_WDPRE2, 0, 0);
		chk({watchdog_expired_flag_o, powerdown_flag_o, wd}, 10'h000);
		exec(MCUIX_OP_HALT, 0, 0);
		wake();
		exec(MCUIX_OP_WDCLR, 0, 0);
		chk({watchdog_expired_flag_o, powerdown_flag_o, wd}, 10'h000);
		idle(2);
		test_done();
	end
endmodule

/* File: tb/mcuix_mem_model.sv */
// Data memory, program memory table port and watchdog counter model
module mcuix_mem_model #(
	parameter logic [15:0] CUR_WORD  = 16'h5ac3,
	parameter logic [15:0] LAST_WORD = 16'ha53c
)
(
	input  wire logic        clock_i,
	input  wire logic [8:0]  mem_addr_i,
	output logic      [7:0]  mem_rdata_o,
	input  wire logic        mem_we_i,
	input  wire logic [8:0]  mem_waddr_i,
	input  wire logic [7:0]  mem_wdata_i,
	input  wire logic        table_req_i,
	input  wire logic        table_last_page_i,
	output logic      [15:0] table_word_o,
	input  wire logic        wd_clear_i,
	output logic      [7:0]  wd_count_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] mem [512];
	assign mem_rdata_o = mem[mem_addr_i];
	always @(posedge clock_i) begin
		if (mem_we_i) begin
			mem[mem_waddr_i] <= mem_wdata_i;
		end
		// Word good only the cycle after a request, scrambled otherwise
		table_word_o <= table_req_i ? (table_last_page_i ? LAST_WORD : CUR_WORD) : ~table_word_o;
		wd_count_o <= wd_clear_i ? 8'h00 : wd_count_o + 8'h01;
	end
endmodule
